// file: logic/asc_regs.svh
// named constants of the converter serial sequencer
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_CTRL_BITS 8
`define ASC_BIT_CNT_FULL 4'h8
`define ASC_TRACK_BIT 4'h5
`define ASC_RES_BITS 12
`define ASC_RES_MSB 4'hb
`define ASC_RES_CNT_FULL 4'hc
`define ASC_MSB_TRIAL 12'h800
`define ASC_MODE_FULL_PD 2'h0
`define ASC_MODE_FAST_PD 2'h1
`define ASC_MODE_INT_CLK 2'h2
`define ASC_MODE_EXT_CLK 2'h3
`define ASC_SHUTDOWN_LEVEL_INPUT_LOW 2'h0
`define ASC_SHUTDOWN_LEVEL_INPUT_FLOAT 2'h1
`define ASC_SHUTDOWN_LEVEL_INPUT_HIGH 2'h3
`define ASC_PAIR_FLIP 3'h1
`define ASC_FIFO_DEPTH 8
`define ASC_INT_DIV 4
`endif

// file: logic/asc_pkg.sv
// types shared by the converter serial sequencer
`include "asc_regs.svh"
package asc_pkg;
    typedef enum logic [1:0] {
        ASC_PD_FULL = `ASC_MODE_FULL_PD,
        ASC_PD_FAST = `ASC_MODE_FAST_PD,
        ASC_INT_CLK = `ASC_MODE_INT_CLK,
        ASC_EXT_CLK = `ASC_MODE_EXT_CLK
    } asc_mode_e;
    typedef struct packed {
        logic start;
        logic [2:0] sel;
        logic unipolar;
        logic single_ended;
        asc_mode_e mode;
    } asc_ctrl_s;
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
        logic neg_gnd;
    } asc_mux_s;
    typedef logic [`ASC_RES_BITS-1:0] asc_result_t;
    typedef enum logic [1:0] {
        RX_HUNT = 2'h1,
        RX_BITS = 2'h2
    } asc_rx_e;
    typedef enum logic [3:0] {
        CV_IDLE = 4'h1,
        CV_EXT = 4'h2,
        CV_INT = 4'h4,
        CV_PUSH = 4'h8
    } asc_cv_e;
endpackage : asc_pkg

// file: logic/asc_fifo.sv
// result fifo with a registered output stage
`timescale 1ns/1ps
module asc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    assign o_in_ready = (count != FULL);
    assign push = i_in_valid && o_in_ready;
    // refill the output stage whenever it is empty or being taken
    assign pop = (count != '0) && (!o_out_valid || i_out_ready);

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end else if (i_ce) begin
            if (pop) begin
                o_out_valid <= 1'b1;
                o_out_data <= mem[rd_ptr];
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
        end
    end
endmodule : asc_fifo

// file: logic/asc_top.sv
// serial control and conversion sequencer of an 8-channel 12-bit converter
`timescale 1ns/1ps
`include "asc_regs.svh"

module asc_top #(
    parameter int INT_DIV = `ASC_INT_DIV,
    parameter int FIFO_DEPTH = `ASC_FIFO_DEPTH
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // serial pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_conversion_strobe,
    output logic o_conversion_strobe_oe,
    // shutdown pin, decoded level code
    input wire logic [1:0] i_shutdown_level_input,
    output logic o_shutdown,
    output logic o_int_comp,
    // analog front end
    input wire logic i_comp,
    output asc_pkg::asc_mux_s o_mux,
    output logic o_track,
    output logic o_hold_on_neg,
    output asc_pkg::asc_result_t o_dac_code,
    output logic o_unipolar,
    output logic o_pd_full,
    output logic o_pd_fast,
    // result stream
    output logic o_res_valid,
    input wire logic i_res_ready,
    output asc_pkg::asc_result_t o_res_data
);
    import asc_pkg::*;

    localparam int DIV_W = (INT_DIV > 1) ? $clog2(INT_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);

    // single-ended channel from select bits; pair partner is the neighbour
    function automatic logic [2:0] asc_pos_chan(input logic [2:0] sel);
        return {sel[1], sel[0], sel[2]};
    endfunction : asc_pos_chan

    function automatic asc_result_t asc_sar_step(input asc_result_t code, input logic [3:0] idx,
                                                 input logic keep);
        asc_result_t r;
        r = code;
        r[idx] = keep;
        if (idx != 4'h0) begin
            r[idx - 4'h1] = 1'b1;
        end
        return r;
    endfunction : asc_sar_step

    // pin synchronisers
    logic cs_s1, cs_s2;
    logic sclk_s1, sclk_s2, sclk_d;
    logic din_s1, din_s2;
    logic comp_s1, comp_s2;
    logic [1:0] shutdown_level_input_s1, shutdown_level_input_s2;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            shutdown_level_input_s1 <= `ASC_SHUTDOWN_LEVEL_INPUT_FLOAT;
            shutdown_level_input_s2 <= `ASC_SHUTDOWN_LEVEL_INPUT_FLOAT;
        end else if (i_ce) begin
            cs_s1 <= i_cs_n;
            cs_s2 <= cs_s1;
            sclk_s1 <= i_sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            din_s1 <= i_din;
            din_s2 <= din_s1;
            comp_s1 <= i_comp;
            comp_s2 <= comp_s1;
            shutdown_level_input_s1 <= i_shutdown_level_input;
            shutdown_level_input_s2 <= shutdown_level_input_s1;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic shutdown;
    assign sclk_rise = sclk_s2 && !sclk_d;
    assign sclk_fall = !sclk_s2 && sclk_d;
    assign shutdown = (shutdown_level_input_s2 == `ASC_SHUTDOWN_LEVEL_INPUT_LOW);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_shutdown <= 1'b0;
            o_int_comp <= 1'b0;
        end else if (i_ce) begin
            o_shutdown <= shutdown;
            o_int_comp <= (shutdown_level_input_s2 == `ASC_SHUTDOWN_LEVEL_INPUT_HIGH);
        end
    end

    // control byte receiver
    asc_rx_e rx_state;
    logic [`ASC_CTRL_BITS-1:0] rx_sh;
    logic [3:0] rx_cnt;
    logic byte_done;
    logic track_fall;
    asc_ctrl_s ctrl_byte;

    assign byte_done = sclk_fall && (rx_state == RX_BITS) && (rx_cnt == `ASC_BIT_CNT_FULL);
    assign track_fall = sclk_fall && (rx_state == RX_BITS) && (rx_cnt == `ASC_TRACK_BIT);
    assign ctrl_byte = asc_ctrl_s'(rx_sh);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_state <= RX_HUNT;
            rx_sh <= '0;
            rx_cnt <= 4'h0;
        end else if (i_ce) begin
            if (cs_s2 || shutdown) begin
                rx_state <= RX_HUNT;
                rx_sh <= '0;
                rx_cnt <= 4'h0;
            end else if (byte_done) begin
                rx_state <= RX_HUNT;
                rx_cnt <= 4'h0;
            end else if (sclk_rise) begin
                unique case (rx_state)
                    RX_HUNT: begin
                        if (din_s2) begin
                            rx_state <= RX_BITS;
                            rx_sh <= {rx_sh[`ASC_CTRL_BITS-2:0], din_s2};
                            rx_cnt <= 4'h1;
                        end
                    end
                    RX_BITS: begin
                        rx_sh <= {rx_sh[`ASC_CTRL_BITS-2:0], din_s2};
                        rx_cnt <= rx_cnt + 4'h1;
                    end
                endcase
            end
        end
    end

    // conversion sequencer
    asc_cv_e cv_state;
    logic [3:0] bit_idx;
    logic [DIV_W-1:0] div_cnt;
    logic ext_mode;
    logic start_conv;
    logic fifo_ready;
    logic conv_mode;

    assign conv_mode = (ctrl_byte.mode == ASC_INT_CLK) || (ctrl_byte.mode == ASC_EXT_CLK);
    // a byte finishing mid conversion is dropped
    assign start_conv = byte_done && (cv_state == CV_IDLE) && conv_mode;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_track <= 1'b0;
            o_mux <= '0;
            o_unipolar <= 1'b0;
            o_pd_full <= 1'b0;
            o_pd_fast <= 1'b0;
            ext_mode <= 1'b0;
        end else if (i_ce) begin
            if (shutdown) begin
                o_track <= 1'b0;
            end else if (track_fall && (cv_state == CV_IDLE)) begin
                o_track <= 1'b1;
                o_mux.pos <= asc_pos_chan(rx_sh[3:1]);
            end else if (byte_done) begin
                o_track <= 1'b0;
            end
            if (byte_done && (cv_state == CV_IDLE)) begin
                // return node: ground or pair partner
                o_mux.pos <= asc_pos_chan(ctrl_byte.sel);
                o_mux.neg <= asc_pos_chan(ctrl_byte.sel) ^ `ASC_PAIR_FLIP;
                o_mux.neg_gnd <= ctrl_byte.single_ended;
                o_unipolar <= ctrl_byte.unipolar;
                o_pd_full <= (ctrl_byte.mode == ASC_PD_FULL);
                o_pd_fast <= (ctrl_byte.mode == ASC_PD_FAST);
                ext_mode <= (ctrl_byte.mode == ASC_EXT_CLK);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cv_state <= CV_IDLE;
            o_dac_code <= '0;
            bit_idx <= 4'h0;
            div_cnt <= '0;
            o_conversion_strobe <= 1'b0;
            o_hold_on_neg <= 1'b0;
        end else if (i_ce) begin
            if (shutdown || (cs_s2 && (cv_state == CV_EXT))) begin
                // no clock to finish an external conversion once deselected
                cv_state <= CV_IDLE;
                o_hold_on_neg <= 1'b0;
                o_conversion_strobe <= 1'b0;
            end else begin
                unique case (cv_state)
                    CV_IDLE: begin
                        if (start_conv) begin
                            o_hold_on_neg <= 1'b1;
                            o_dac_code <= `ASC_MSB_TRIAL;
                            bit_idx <= `ASC_RES_MSB;
                            div_cnt <= '0;
                            if (ctrl_byte.mode == ASC_EXT_CLK) begin
                                // strobe high one period before msb
                                o_conversion_strobe <= 1'b1;
                                cv_state <= CV_EXT;
                            end else begin
                                o_conversion_strobe <= 1'b0;
                                cv_state <= CV_INT;
                            end
                        end
                    end
                    CV_EXT: begin
                        // one decision per host clock fall
                        if (sclk_fall) begin
                            o_conversion_strobe <= 1'b0;
                            o_dac_code <= asc_sar_step(o_dac_code, bit_idx, comp_s2);
                            bit_idx <= bit_idx - 4'h1;
                            if (bit_idx == 4'h0) begin
                                cv_state <= CV_PUSH;
                            end
                        end
                    end
                    CV_INT: begin
                        if (div_cnt == DIV_LAST) begin
                            div_cnt <= '0;
                            o_dac_code <= asc_sar_step(o_dac_code, bit_idx, comp_s2);
                            bit_idx <= bit_idx - 4'h1;
                            if (bit_idx == 4'h0) begin
                                cv_state <= CV_PUSH;
                            end
                        end else begin
                            div_cnt <= div_cnt + 1'b1;
                        end
                    end
                    CV_PUSH: begin
                        // twelve-bit word leaves; waits while fifo is full
                        if (fifo_ready) begin
                            o_hold_on_neg <= 1'b0;
                            o_conversion_strobe <= !ext_mode;
                            cv_state <= CV_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // serial output shifter
    asc_result_t out_sh;
    logic [3:0] out_cnt;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_dout <= 1'b0;
            out_sh <= '0;
            out_cnt <= 4'h0;
        end else if (i_ce) begin
            if (cv_state == CV_PUSH && fifo_ready && !ext_mode) begin
                out_sh <= o_dac_code;
                out_cnt <= `ASC_RES_CNT_FULL;
            end else if (sclk_fall) begin
                // bits change on falls, msb first
                // msb decision leaves on the fall that ends the strobe pulse
                if (cv_state == CV_EXT) begin
                    o_dout <= comp_s2;
                end else if (out_cnt != 4'h0) begin
                    o_dout <= out_sh[`ASC_RES_MSB];
                    out_sh <= {out_sh[`ASC_RES_BITS-2:0], 1'b0};
                    out_cnt <= out_cnt - 4'h1;
                end else begin
                    o_dout <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_dout_oe <= 1'b0;
            o_conversion_strobe_oe <= 1'b0;
        end else if (i_ce) begin
            o_dout_oe <= !cs_s2;
            // strobe released only in external mode
            o_conversion_strobe_oe <= !cs_s2 || !ext_mode;
        end
    end

    asc_fifo #(
        .WIDTH(`ASC_RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_in_valid(cv_state == CV_PUSH),
        .o_in_ready(fifo_ready),
        .i_in_data(o_dac_code),
        .o_out_valid(o_res_valid),
        .i_out_ready(i_res_ready),
        .o_out_data(o_res_data)
    );
endmodule : asc_top

// file: test/asc_top_checker.sv
// pin-level assertions of the converter serial sequencer
`timescale 1ns/1ps
module asc_top_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // serial and shutdown pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic [1:0] i_shutdown_level_input,
    input wire logic o_dout,
    input wire logic o_dout_oe,
    input wire logic o_conversion_strobe,
    input wire logic o_conversion_strobe_oe,
    // converter state
    input wire logic o_shutdown,
    input wire logic o_int_comp,
    input wire logic o_track,
    input wire logic o_hold_on_neg,
    input wire logic o_res_valid,
    input wire logic o_pd_full,
    input wire logic o_pd_fast
);
    logic sclk_q;
    logic [3:0] fall_age;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    always_ff @(posedge i_clk) begin
        sclk_q <= i_sclk;
    end

    // age since a raw clock fall; pins reach the logic a few cycles late through the synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fall_age <= 4'hf;
        end else if (sclk_q && !i_sclk) begin
            fall_age <= 4'h0;
        end else if (fall_age != 4'hf) begin
            fall_age <= fall_age + 4'h1;
        end
    end

    sequence cs_low_held;
        !i_cs_n [*4];
    endsequence
    sequence cs_high_held;
        i_cs_n [*4];
    endsequence
    sequence ext_pulse;
        o_conversion_strobe [*8] ##1 !o_conversion_strobe;
    endsequence
    sequence int_busy;
        !o_conversion_strobe [*8];
    endsequence

    dout_edge_a: assert property ($changed(o_dout) && o_dout_oe && $past(o_dout_oe) |-> fall_age <= 4'h6)
        else $error("dout moved away from a clock fall");
    dout_release_a: assert property (cs_high_held |-> !o_dout_oe)
        else $error("dout driven while deselected");
    strobe_drive_a: assert property (cs_low_held |-> o_conversion_strobe_oe)
        else $error("strobe not driven while selected");
    track_start_a: assert property ($rose(o_track) |-> fall_age <= 4'h6)
        else $error("tracking began away from a clock fall");
    hold_start_a: assert property ($fell(o_track) && !o_shutdown |-> fall_age <= 4'h6)
        else $error("hold began away from a clock fall");
    // power-down bytes also end tracking but start no conversion
    hold_conv_a: assert property ($fell(o_track) && !o_shutdown && !o_pd_full && !o_pd_fast
        |-> o_hold_on_neg) else $error("hold began without a conversion");
    strobe_pulse_a: assert property ($rose(o_hold_on_neg) && o_conversion_strobe |-> ext_pulse)
        else $error("strobe pulse not one serial period");
    strobe_low_a: assert property ($rose(o_hold_on_neg) && !o_conversion_strobe |-> int_busy)
        else $error("strobe rose early in a conversion");
    push_result_a: assert property ($fell(o_hold_on_neg) && !o_shutdown |-> ##[0:3] o_res_valid)
        else $error("conversion ended without a result word");
    shutdown_level_input_off_a: assert property ((i_shutdown_level_input == 2'h0) [*4] |-> o_shutdown && !o_int_comp)
        else $error("low shutdown level not decoded");
    shutdown_level_input_comp_a: assert property ((i_shutdown_level_input == 2'h3) [*4] |-> o_int_comp && !o_shutdown)
        else $error("high shutdown level not decoded");
endmodule : asc_top_checker

bind asc_top asc_top_checker u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
    .i_shutdown_level_input(i_shutdown_level_input), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
    .o_conversion_strobe(o_conversion_strobe), .o_conversion_strobe_oe(o_conversion_strobe_oe),
    .o_shutdown(o_shutdown), .o_int_comp(o_int_comp), .o_track(o_track), .o_hold_on_neg(o_hold_on_neg),
    .o_res_valid(o_res_valid), .o_pd_full(o_pd_full), .o_pd_fast(o_pd_fast)
);

// file: test/asc_host_model.sv
// serial host that frames control bytes and reads results back
`timescale 1ns/1ps
module asc_host_model (
    // bench clock
    input wire logic i_clk,
    // serial pins toward the converter
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din,
    input wire logic i_dout
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end

    // idle; a deselected data line never keeps its last value
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge i_clk);
            if (o_cs_n) o_din = ~o_din;
        end
    endtask : tick

    // bit set at fall, even duty
    task automatic cyc(input logic b, output logic q);
        o_din = b;
        tick(4);
        o_sclk = 1'b1;
        q = i_dout;
        tick(4);
        o_sclk = 1'b0;
    endtask : cyc

    task automatic open();
        o_cs_n = 1'b0;
        tick(8);
    endtask : open

    task automatic close();
        tick(4);
        o_cs_n = 1'b1;
        tick(8);
    endtask : close

    task automatic send(input logic [7:0] c, input int lead, input int nb);
        logic q;
        repeat (lead) cyc(1'b0, q);
        for (int i = 7; i > 7 - nb; i--) begin
            cyc(c[i], q);
            // clock parked so the input settles
            if (i == 3) tick(150);
        end
    endtask : send

    task automatic shift(input int n, output logic [23:0] rd);
        logic q;
        rd = 24'h0;
        repeat (n) begin
            cyc(1'b0, q);
            rd = {rd[22:0], q};
        end
    endtask : shift
endmodule : asc_host_model

// file: test/asc_top_tb_top.sv
// self-checking bench of the converter serial sequencer
`timescale 1ns/1ps
module asc_top_tb_top;
    import asc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce;
    logic [1:0] shutdown_level_input_lvl = 2'h1;
    logic comp;
    logic res_ready = 1'b1;
    logic cs_n, sclk, din, dout, dout_oe, strobe, strobe_oe;
    logic shutdown, int_comp, track, hold_neg, unipolar, pd_full, pd_fast, res_valid;
    asc_mux_s mux;
    asc_result_t dac, res_data;
    logic [11:0] target = 12'h0;
    logic [11:0] exp_q[$];
    int n_fail = 0;
    int checks = 0;

    always #5 clk = ~clk;

    asc_top dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
        .o_dout(dout), .o_dout_oe(dout_oe), .o_conversion_strobe(strobe), .o_conversion_strobe_oe(strobe_oe),
        .i_shutdown_level_input(shutdown_level_input_lvl), .o_shutdown(shutdown), .o_int_comp(int_comp), .i_comp(comp),
        .o_mux(mux), .o_track(track), .o_hold_on_neg(hold_neg), .o_dac_code(dac), .o_unipolar(unipolar),
        .o_pd_full(pd_full), .o_pd_fast(pd_fast), .o_res_valid(res_valid), .i_res_ready(res_ready),
        .o_res_data(res_data)
    );

    asc_host_model u_host (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout));

    // ideal comparator, so a full search lands on the target
    always @(negedge clk) begin
        comp <= (dac <= target);
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic conv(input logic [7:0] c, input int lead, input bit stall, input bit freeze);
        logic [23:0] rd;
        int i;
        target = 12'($urandom);
        if (c[1]) exp_q.push_back(target);
        u_host.open();
        u_host.send(c, lead, 8);
        if (c[1:0] == ASC_INT_CLK) begin
            u_host.tick(8);
            check("strobe low", 1'b0, strobe);
            if (freeze) begin
                // enable low must hold the conversion well past its normal length
                ce = 1'b0;
                u_host.tick(100);
                check("strobe frozen", 1'b0, strobe);
                ce = 1'b1;
            end
            if (stall) begin
                u_host.tick(200);
                check("strobe held", 1'b0, strobe);
                res_ready = 1'b1;
            end
            for (i = 0; i < 500 && strobe !== 1'b1; i++) u_host.tick(1);
            if (i == 500) begin
                n_fail++;
                wrap_up();
            end
        end
        if (c[1]) begin
            u_host.shift(13, rd);
            check("serial result", target, rd[11:0]);
        end
        u_host.close();
        check("mux", {c[5], c[4], c[6], c[5], c[4], ~c[6], c[2]}, mux);
        check("unipolar", c[3], unipolar);
        check("pd full", c[1:0] == 2'h0, pd_full);
        check("pd fast", c[1:0] == 2'h1, pd_fast);
        check("dout released", 1'b0, dout_oe);
        check("strobe released", c[1:0] != 2'h3, strobe_oe);
    endtask : conv

    always @(posedge clk) begin
        if (rst_n && res_valid === 1'b1 && res_ready === 1'b1) begin
            if (exp_q.size() == 0) check("extra word", 32'h0, 32'h1);
            else check("fifo word", exp_q.pop_front(), res_data);
        end
    end

    initial begin
        logic [7:0] c;
        ce = 1'b1;
        void'($urandom(32'ha19d295e));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        u_host.tick(4);
        for (int k = 0; k < 3; k++) begin
            shutdown_level_input_lvl = (k == 0) ? 2'h0 : (k == 1) ? 2'h3 : 2'h1;
            u_host.tick(6);
            check("shutdown", k == 0, shutdown);
            check("int comp", k == 1, int_comp);
        end
        for (int k = 0; k < 8; k++) begin
            c = {1'b1, 5'($urandom), 2'(k)};
            conv(c, k, 1'b0, k == 2);
        end
        // half a byte then deselect; the next byte must parse from its own start bit
        u_host.open();
        u_host.send(8'hf0, 0, 4);
        u_host.close();
        conv(8'ha7, 0, 1'b0, 1'b0);
        res_ready = 1'b0;
        for (int k = 0; k < 10; k++) begin
            c = {1'b1, 5'($urandom), 2'h2};
            conv(c, 0, k == 9, 1'b0);
        end
        for (int k = 0; k < 100 && exp_q.size() != 0; k++) u_host.tick(1);
        check("words left", 32'h0, exp_q.size());
        wrap_up();
    end
endmodule : asc_top_tb_top
